// ---- pkg/ctm_pkg.sv ----
package ctm_pkg;

  // register offsets inside a pair stride, and the shared status words
  localparam logic [11:0] CTM_PAIR_STRIDE   = 12'h010;
  localparam logic [3:0]  CTM_OFF_COUNT     = 4'h0;
  localparam logic [3:0]  CTM_OFF_CMP_A     = 4'h4;
  localparam logic [3:0]  CTM_OFF_CMP_B     = 4'h8;
  localparam logic [3:0]  CTM_OFF_CTRL      = 4'hc;
  localparam logic [11:0] CTM_OFF_STATUS    = 12'h204;
  localparam logic [11:0] CTM_OFF_CLEAR     = 12'h208;

  // counts
  localparam int          CTM_PAIRS         = 4;
  localparam int          CTM_HALVES        = 8;
  localparam int          CTM_TRIG_PAIR     = 3;

  // control field positions within one half (half b adds CTM_HALF_SHIFT); trigger enable and link are whole-pair bits
  localparam int          CTM_HALF_SHIFT    = 16;
  localparam int          CTM_CTL_EN        = 0;
  localparam int          CTM_CTL_CLK_LSB   = 1;
  localparam int          CTM_CTL_FN_LSB    = 6;
  localparam int          CTM_CTL_IE0       = 9;
  localparam int          CTM_CTL_IE1       = 10;
  localparam int          CTM_CTL_CLR       = 11;
  localparam int          CTM_CTL_POL       = 12;
  localparam int          CTM_CTL_PE        = 13;
  localparam int          CTM_CTL_TRIG_EN   = 30;
  localparam int          CTM_CTL_LINK      = 31;

  // reset values
  localparam logic [31:0] CTM_CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTM_CMP_RESET     = 32'h0000_0000;
  localparam logic [7:0]  CTM_STATUS_RESET  = 8'h00;

  // wrap points
  localparam logic [31:0] CTM_TOP_16        = 32'h0000_ffff;
  localparam logic [31:0] CTM_TOP_32        = 32'hffff_ffff;

  // counting clock selections; system clock stands in for the fast oscillator
  localparam logic [4:0]  CTM_CLK_PIN       = 5'h00;
  localparam logic [4:0]  CTM_CLK_DIV4      = 5'h01;
  localparam logic [4:0]  CTM_CLK_DIV16     = 5'h02;
  localparam logic [4:0]  CTM_CLK_DIV256    = 5'h03;
  localparam logic [4:0]  CTM_CLK_DIV1024   = 5'h04;
  localparam logic [4:0]  CTM_CLK_DIV4096   = 5'h05;
  localparam logic [4:0]  CTM_CLK_QUARTER   = 5'h0f;
  localparam int          CTM_DIV_BITS      = 12;

  typedef enum logic [2:0] {
    CTM_FN_SINGLE_COUNT = 3'b000,
    CTM_FN_REPEAT_COUNT = 3'b001,
    CTM_FN_SINGLE_PULSE = 3'b010,
    CTM_FN_REPEAT_PULSE = 3'b011,
    CTM_FN_CONTINUOUS   = 3'b100
  } ctm_fn_type;

endpackage

// ---- rtl/ctm_sync3.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctm_sync3
  import ctm_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // pin side
  input  wire logic async_in,
  // filtered side
  output logic      level,
  output logic      rise
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_reg;
  logic rise_reg;
  wire  agree_change = (stage2_reg == stage3_reg) && (stage3_reg != level_reg);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
      level_reg  <= 1'b0;
      rise_reg   <= 1'b0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      rise_reg   <= agree_change && stage3_reg;
      if (agree_change) begin
        level_reg <= stage3_reg;
      end
    end
  end

  assign level = level_reg;
  assign rise  = rise_reg;

endmodule
`default_nettype wire

// ---- rtl/ctm_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctm_engine
  import ctm_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // control
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic        counter_hold_zero,
  input  wire logic [2:0]  function_select,
  input  wire logic [31:0] compare_low,
  input  wire logic [31:0] compare_high,
  input  wire logic [31:0] top,
  // state
  output logic [31:0]      count,
  output logic             level,
  output logic             low_event,
  output logic             high_event
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        level_reg;
  logic        level_next;
  logic        stopped_reg;
  logic        stopped_next;
  logic        seen_reg;
  logic        seen_next;
  logic        low_next;
  logic        high_next;
  logic        low_reg;
  logic        high_reg;

  wire         hit_low  = (count_reg == compare_low);
  wire         hit_high = (count_reg == compare_high);
  wire [31:0]  count_inc = count_reg + 32'h0000_0001;
  wire         step     = tick && enable && !stopped_reg;

  always_comb begin
    count_next   = count_reg;
    level_next   = level_reg;
    stopped_next = stopped_reg;
    seen_next    = seen_reg;
    low_next     = 1'b0;
    high_next    = 1'b0;
    if (counter_hold_zero) begin
      count_next   = '0;
      level_next   = 1'b0;
      stopped_next = 1'b0;
      seen_next    = 1'b0;
    end else if (step) begin
      count_next = count_inc;
      unique case (function_select)
        CTM_FN_SINGLE_COUNT: begin
          if (hit_low) begin
            count_next   = '0;
            level_next   = !level_reg;
            stopped_next = 1'b1;
            low_next     = 1'b1;
          end
        end
        CTM_FN_REPEAT_COUNT: begin
          level_next = hit_low;
          if (hit_low) begin
            count_next = '0;
            low_next   = 1'b1;
          end
        end
        CTM_FN_SINGLE_PULSE, CTM_FN_REPEAT_PULSE: begin
          if (hit_low) begin
            level_next = 1'b1;
            low_next   = 1'b1;
          end else if (hit_high) begin
            level_next = 1'b0;
            count_next = '0;
            high_next  = 1'b1;
            stopped_next = (function_select == CTM_FN_SINGLE_PULSE);
          end
        end
        CTM_FN_CONTINUOUS: begin
          if (count_reg == top) begin
            count_next = '0;
          end
          if (hit_low && !seen_reg) begin
            level_next = 1'b1;
            seen_next  = 1'b1;
            low_next   = 1'b1;
          end
        end
        default: begin
          count_next = count_reg;
        end
      endcase
    end
  end

  // counter holds its value while enable is low so a paused sequence resumes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg   <= '0;
      level_reg   <= 1'b0;
      stopped_reg <= 1'b0;
      seen_reg    <= 1'b0;
      low_reg     <= 1'b0;
      high_reg    <= 1'b0;
    end else begin
      count_reg   <= count_next;
      level_reg   <= level_next;
      stopped_reg <= stopped_next;
      seen_reg    <= seen_next;
      low_reg     <= low_next;
      high_reg    <= high_next;
    end
  end

  assign count      = count_reg;
  assign level      = level_reg;
  assign low_event  = low_reg;
  assign high_event = high_reg;

endmodule
`default_nettype wire

// ---- rtl/ctm_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctm_top
  import ctm_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // timer pins, bit 2p is half a and bit 2p+1 half b of pair p
  input  wire logic [7:0]  timer_pin_in,
  output logic [7:0]       timer_pin_out,
  // converter trigger and interrupt
  output logic             converter_trigger,
  output logic             timer_irq
);

  // register file
  logic [31:0] ctrl_reg [CTM_PAIRS];
  logic [31:0] cmp_reg [CTM_HALVES];
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [7:0]  pin_out_reg;
  logic        trigger_reg;
  logic        irq_reg;
  logic [CTM_DIV_BITS-1:0] div_reg;

  // per half signals
  logic [31:0] half_count [CTM_HALVES];
  logic [7:0]  half_level;
  logic [7:0]  half_low_event;
  logic [7:0]  half_high_event;
  logic [7:0]  pin_rise;
  logic [7:0]  half_irq_enable;
  logic [7:0]  half_pin_next;

  // bus decode
  wire         setup_phase  = psel && !penable && !pready_reg;
  wire         access_done  = psel && penable && pready_reg;
  wire         in_pairs     = (paddr[11:6] == 6'h00);
  wire [1:0]   dec_pair     = paddr[5:4];
  wire [3:0]   dec_off      = paddr[3:0];
  wire         hit_count    = in_pairs && (dec_off == CTM_OFF_COUNT);
  wire         hit_cmp_a    = in_pairs && (dec_off == CTM_OFF_CMP_A);
  wire         hit_cmp_b    = in_pairs && (dec_off == CTM_OFF_CMP_B);
  wire         hit_ctrl     = in_pairs && (dec_off == CTM_OFF_CTRL);
  wire         hit_status   = (paddr == CTM_OFF_STATUS);
  wire         hit_clear    = (paddr == CTM_OFF_CLEAR);
  wire         hit_any      = hit_count || hit_cmp_a || hit_cmp_b || hit_ctrl ||
                              hit_status || hit_clear;
  wire         write_ok     = access_done && pwrite && hit_any;
  wire [31:0]  pair_count   = ctrl_reg[dec_pair][CTM_CTL_LINK] ?
                              half_count[{dec_pair, 1'b0}] :
                              {half_count[{dec_pair, 1'b1}][15:0],
                               half_count[{dec_pair, 1'b0}][15:0]};
  wire [31:0]  read_value   = hit_count  ? pair_count :
                              hit_cmp_a  ? cmp_reg[{dec_pair, 1'b0}] :
                              hit_cmp_b  ? cmp_reg[{dec_pair, 1'b1}] :
                              hit_ctrl   ? ctrl_reg[dec_pair] :
                              hit_status ? {24'h000000, status_reg} :
                              32'h0000_0000;
  wire [7:0]   clear_mask   = (write_ok && hit_clear) ? pwdata[7:0] : 8'h00;

  // divided ticks; the fast oscillator is modelled by the system clock
  wire         tick_div4    = (div_reg[1:0] == 2'h3);
  wire         tick_div16   = (div_reg[3:0] == 4'hf);
  wire         tick_div256  = (div_reg[7:0] == 8'hff);
  wire         tick_div1024 = (div_reg[9:0] == 10'h3ff);
  wire         tick_div4096 = (div_reg == 12'hfff);

  function automatic logic pick_tick(input logic [4:0] sel, input logic pin_tick);
    logic t;
    t = 1'b0;
    case (sel)
      CTM_CLK_PIN:     t = pin_tick;
      CTM_CLK_DIV4:    t = tick_div4;
      CTM_CLK_DIV16:   t = tick_div16;
      CTM_CLK_DIV256:  t = tick_div256;
      CTM_CLK_DIV1024: t = tick_div1024;
      CTM_CLK_DIV4096: t = tick_div4096;
      CTM_CLK_QUARTER: t = tick_div4;
      default:         t = 1'b0;
    endcase
    return t;
  endfunction

  genvar g;
  generate
    for (g = 0; g < CTM_HALVES; g = g + 1) begin : gen_half
      localparam int PAIR = g / 2;
      localparam int HB   = g % 2;
      localparam int BASE = HB * CTM_HALF_SHIFT;
      wire        linked   = ctrl_reg[PAIR][CTM_CTL_LINK];
      wire [31:0] ctl      = ctrl_reg[PAIR];
      wire [31:0] cmp_own  = cmp_reg[g];
      wire [31:0] cmp_pa   = cmp_reg[PAIR * 2];
      wire [31:0] cmp_pb   = cmp_reg[PAIR * 2 + 1];
      wire [31:0] low_val  = (HB == 0 && linked) ? {cmp_pb[15:0], cmp_pa[15:0]} :
                                                   {16'h0000, cmp_own[15:0]};
      wire [31:0] high_val = (HB == 0 && linked) ? {cmp_pb[31:16], cmp_pa[31:16]} :
                                                   {16'h0000, cmp_own[31:16]};
      wire [31:0] top_val  = (HB == 0 && linked) ? CTM_TOP_32 : CTM_TOP_16;
      wire        en_bit   = ctl[BASE + CTM_CTL_EN] && !(HB == 1 && linked);
      wire        clr_bit  = ctl[BASE + CTM_CTL_CLR] || (HB == 1 && linked);
      wire        pol_bit  = ctl[BASE + CTM_CTL_POL];
      wire        pe_bit   = ctl[BASE + CTM_CTL_PE];
      wire        tick_sel = pick_tick(ctl[BASE + CTM_CTL_CLK_LSB +: 5], pin_rise[g]);

      ctm_sync3 u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (timer_pin_in[g]),
        .level    (),
        .rise     (pin_rise[g])
      );

      ctm_engine u_engine (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .tick              (tick_sel),
        .enable            (en_bit),
        .counter_hold_zero (clr_bit),
        .function_select   (ctl[BASE + CTM_CTL_FN_LSB +: 3]),
        .compare_low       (low_val),
        .compare_high      (high_val),
        .top               (top_val),
        .count             (half_count[g]),
        .level             (half_level[g]),
        .low_event         (half_low_event[g]),
        .high_event        (half_high_event[g])
      );

      assign half_irq_enable[g] = ctl[BASE + CTM_CTL_IE0];
      assign half_pin_next[g]   = pe_bit ? (half_level[g] ^ pol_bit) : pol_bit;
    end
  endgenerate

  // event wins over a clear in the same cycle
  assign status_next = (status_reg & ~clear_mask) | half_low_event;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 12'h001;
    end
  end

  // apb answers in the first access cycle, no wait states
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase && !hit_any;
      prdata_reg  <= (setup_phase && !pwrite) ? read_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CTM_PAIRS; i++) begin
        ctrl_reg[i] <= CTM_CTRL_RESET;
      end
      for (int i = 0; i < CTM_HALVES; i++) begin
        cmp_reg[i] <= CTM_CMP_RESET;
      end
    end else if (write_ok) begin
      if (hit_ctrl) begin
        ctrl_reg[dec_pair] <= pwdata;
      end
      if (hit_cmp_a) begin
        cmp_reg[{dec_pair, 1'b0}] <= pwdata;
      end
      if (hit_cmp_b) begin
        cmp_reg[{dec_pair, 1'b1}] <= pwdata;
      end
    end
  end

  // pin, trigger and irq all leave through flip-flops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg  <= CTM_STATUS_RESET;
      pin_out_reg <= 8'h00;
      trigger_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      status_reg  <= status_next;
      pin_out_reg <= half_pin_next;
      trigger_reg <= ctrl_reg[CTM_TRIG_PAIR][CTM_CTL_TRIG_EN] &&
                     half_level[CTM_TRIG_PAIR * 2];
      irq_reg     <= |(status_next & half_irq_enable);
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign timer_pin_out     = pin_out_reg;
  assign converter_trigger = trigger_reg;
  assign timer_irq         = irq_reg;

endmodule
`default_nettype wire

// ---- tb/ctm_top_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctm_top_chk
  import ctm_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [7:0]  timer_pin_in,
  input wire logic [7:0]  timer_pin_out,
  input wire logic        converter_trigger,
  input wire logic        timer_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // bus shadows; calm holds off until more than eight cycles after the last control write
  logic [31:0] ctl0_reg;
  logic [31:0] ctl3_reg;
  logic [7:0]  ie_reg;
  logic [3:0]  age_reg;
  wire logic   ctl_wr = psel && penable && pready && pwrite && paddr < 12'h040 &&
                        paddr[3:0] == 4'hc;
  wire logic   calm   = age_reg > 4'h8;
  wire logic   mapped = paddr < 12'h040 || paddr == 12'h204 || paddr == 12'h208;
  wire logic   rd_acc = pready && !pwrite;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {ctl0_reg, ctl3_reg, ie_reg, age_reg} <= '0;
    end else begin
      if (ctl_wr && paddr[5:4] == 2'd0) ctl0_reg <= pwdata;
      if (ctl_wr && paddr[5:4] == 2'd3) ctl3_reg <= pwdata;
      if (ctl_wr) ie_reg[{paddr[5:4], 1'b0}] <= pwdata[9];
      if (ctl_wr) ie_reg[{paddr[5:4], 1'b1}] <= pwdata[25];
      age_reg <= ctl_wr ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (s_setup |=> s_access)
    else $error("no ready after setup");
  a_ready_pulse: assert property ($rose(pready) |=> $fell(pready))
    else $error("ready longer than one cycle");
  a_err_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
    else $error("error flag does not match map");
  a_rdata_idle: assert property (!rd_acc |-> prdata == 32'h0)
    else $error("read data outside read access");
  a_clear_reads0: assert property (rd_acc && paddr == 12'h208 |-> prdata == 32'h0)
    else $error("clear word reads nonzero");
  a_pin_pol: assert property (calm && !ctl0_reg[13] |-> timer_pin_out[0] == ctl0_reg[12])
    else $error("undriven pin not at invert level");
  a_hold_zero: assert property (rd_acc && paddr == 12'h000 && calm && ctl0_reg[11]
    |-> prdata[15:0] == 16'h0)
    else $error("held counter not zero");
  a_trig_off: assert property ((calm && !ctl3_reg[30]) [*2] |-> !converter_trigger)
    else $error("trigger while disabled");
  a_irq_off: assert property (calm && ie_reg == 8'h00 |-> !timer_irq)
    else $error("irq with all enables off");
endmodule
`default_nettype wire

// ---- tb/ctm_load.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctm_load (
  // clock and reset
  input  wire logic   clock,
  input  wire logic   sys_rst,
  // far side
  input  wire logic   run,
  input  wire logic   trig,
  output logic [7:0]  pin_in,
  output logic [15:0] trig_edges,
  output logic [15:0] pin_rises
);
  logic       trig_d;
  logic [3:0] div;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {trig_d, div, pin_in, trig_edges, pin_rises} <= '0;
    end else begin
      trig_d <= trig;
      // converter takes one sample per rising trigger
      if (trig && !trig_d) trig_edges <= trig_edges + 16'h1;
      div <= run ? div + 4'h1 : 4'h0;
      if (run && div == 4'hf) pin_in <= ~pin_in;
      if (run && div == 4'hf && !pin_in[4]) pin_rises <= pin_rises + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ctm_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        run = 1'b0;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, converter_trigger, timer_irq;
  wire logic [7:0]  timer_pin_in, timer_pin_out;
  wire logic [15:0] trig_edges, pin_rises;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n, w, l, num, lo, hi;
  logic [31:0] rd, v;
  logic        err;
  logic [15:0] c, b16;

  always #25 clock = ~clock;

  ctm_top i_ctm_top (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
    .converter_trigger(converter_trigger), .timer_irq(timer_irq));
  ctm_load i_ctm_load (.clock(clock), .sys_rst(sys_rst), .run(run), .trig(converter_trigger),
    .pin_in(timer_pin_in), .trig_edges(trig_edges), .pin_rises(pin_rises));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until ready is sampled, hangs end at the bench timeout
  task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] hc(input logic [2:0] fn, input logic ie, input logic level_invert,
                                     input logic pe, input logic en, input logic [4:0] cs);
    return {2'b00, pe, level_invert, 1'b0, 1'b0, ie, fn, cs, en};
  endfunction

  // ticks every four clocks at divide-by-four
  function automatic logic [31:0] per(input int k);
    return 32'((k + 1) * 4);
  endfunction

  // hold at zero first so the run starts from a cleared count
  task automatic go(input logic [11:0] base, input logic [31:0] cmp, input logic [15:0] ctl,
                    input logic [15:0] top);
    xfer(1'b1, base + 12'h004, cmp);
    xfer(1'b1, base + 12'h00c, {top, (ctl & 16'hfffe) | 16'h0800});
    repeat (8) @(posedge clock);
    xfer(1'b1, base + 12'h00c, {top, ctl});
  endtask

  task automatic gap(input int bi, input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (timer_pin_out[bi] !== lvl && k < 1000);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    void'($urandom(23));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    xfer(1'b0, 12'h00c, 32'h0);
    chk(rd, CTM_CTRL_RESET);
    xfer(1'b0, 12'h204, 32'h0);
    chk(rd, {24'h0, CTM_STATUS_RESET});
    xfer(1'b1, 12'h100, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    xfer(1'b0, 12'h100, 32'h0);
    chk(rd | 32'(err), 32'h1);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      xfer(1'b1, 12'(16 * (i / 2) + 4 + 4 * (i % 2)), v);
      xfer(1'b0, 12'(16 * (i / 2) + 4 + 4 * (i % 2)), 32'h0);
      chk(rd, v);
    end
    num = 1 + $urandom % 6;
    go(12'h000, 32'(num), hc(CTM_FN_REPEAT_COUNT, 1'b1, 1'b0, 1'b1, 1'b1, CTM_CLK_DIV4), 16'h0);
    gap(0, 1'b1, n);
    gap(0, 1'b0, w);
    gap(0, 1'b1, l);
    chk(32'(w), 32'd4);
    chk(32'(w + l), per(num));
    xfer(1'b0, 12'h204, 32'h0);
    chk(rd, 32'h1);
    chk(32'(timer_irq), 32'h1);
    xfer(1'b1, 12'h00c, {16'h0, hc(CTM_FN_REPEAT_COUNT, 1'b1, 1'b0, 1'b1, 1'b0, CTM_CLK_DIV4)});
    repeat (20) @(posedge clock);
    xfer(1'b1, 12'h208, 32'h1);
    xfer(1'b0, 12'h204, 32'h0);
    chk(rd, 32'h0);
    repeat (4) @(posedge clock);
    chk(32'(timer_irq), 32'h0);
    c = hc(CTM_FN_CONTINUOUS, 1'b1, 1'b0, 1'b1, 1'b1, CTM_CLK_DIV4);
    go(12'h000, 32'h3, c, 16'h0);
    repeat (200) @(posedge clock);
    xfer(1'b1, 12'h00c, {16'h0, c & 16'hfffe});
    repeat (8) @(posedge clock);
    xfer(1'b0, 12'h000, 32'h0);
    v = rd;
    repeat (40) @(posedge clock);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd, v);
    chk(32'(v[15:0] > 16'h3), 32'h1);
    chk(32'(timer_pin_out[0]), 32'h1);
    xfer(1'b1, 12'h00c, {16'h0, c});
    repeat (40) @(posedge clock);
    xfer(1'b0, 12'h000, 32'h0);
    chk(32'(rd[15:0] > v[15:0]), 32'h1);
    xfer(1'b1, 12'h00c, {16'h0, c | 16'h0800});
    repeat (8) @(posedge clock);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd & 32'hffff, 32'h0);
    go(12'h000, 32'h5, hc(CTM_FN_SINGLE_COUNT, 1'b1, 1'b0, 1'b1, 1'b1, CTM_CLK_DIV4), 16'h0);
    repeat (100) @(posedge clock);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(32'(timer_pin_out[0]), 32'h1);
    for (int f = 2; f < 4; f++) begin
      lo = 1 + $urandom % 4;
      hi = lo + 1 + $urandom % 4;
      go(12'h000, {16'(hi), 16'(lo)}, hc(3'(f), 1'b1, 1'b0, 1'b1, 1'b1, CTM_CLK_DIV4), 16'h0);
      gap(0, 1'b1, n);
      gap(0, 1'b0, w);
      gap(0, 1'b1, l);
      chk(32'(w), 32'(4 * (hi - lo)));
      chk(32'(w + l), f == 3 ? per(hi) : 32'(w + 1000));
    end
    go(12'h000, 32'h1, hc(CTM_FN_REPEAT_COUNT, 1'b0, 1'b0, 1'b1, 1'b1, CTM_CLK_DIV16), 16'h0);
    gap(0, 1'b1, n);
    gap(0, 1'b0, w);
    gap(0, 1'b1, l);
    chk(32'(w), 32'd16);
    chk(32'(w + l), 32'd32);
    // unused function code must leave the count parked at zero
    go(12'h000, 32'h1, hc(3'h5, 1'b0, 1'b0, 1'b1, 1'b1, CTM_CLK_DIV4), 16'h0);
    repeat (40) @(posedge clock);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    go(12'h010, 32'h1, hc(CTM_FN_CONTINUOUS, 1'b0, 1'b0, 1'b0, 1'b1, CTM_CLK_DIV4), 16'h8800);
    repeat (400) @(posedge clock);
    xfer(1'b0, 12'h010, 32'h0);
    chk(32'(rd >= 32'd90 && rd <= 32'd110), 32'h1);
    go(12'h020, 32'h1, hc(CTM_FN_CONTINUOUS, 1'b0, 1'b0, 1'b0, 1'b1, CTM_CLK_PIN), 16'h0);
    b16 = pin_rises;
    run <= 1'b1;
    repeat (300) @(posedge clock);
    run <= 1'b0;
    repeat (20) @(posedge clock);
    xfer(1'b0, 12'h020, 32'h0);
    chk(rd & 32'hffff, 32'(pin_rises - b16));
    b16 = trig_edges;
    c = hc(CTM_FN_REPEAT_COUNT, 1'b1, 1'b1, 1'b0, 1'b1, CTM_CLK_QUARTER);
    go(12'h030, 32'h3, c, 16'h4000);
    repeat (400) @(posedge clock);
    chk(32'(trig_edges - b16 >= 16'd20), 32'h1);
    chk(32'(timer_irq), 32'h1);
    xfer(1'b0, 12'h204, 32'h0);
    chk(rd & 32'h40, 32'h40);
    chk(32'(timer_pin_out[6]), 32'h1);
    xfer(1'b1, 12'h03c, {16'h0, c});
    repeat (20) @(posedge clock);
    b16 = trig_edges;
    repeat (100) @(posedge clock);
    chk(32'(trig_edges), 32'(b16));
    final_report();
  end
endmodule

bind ctm_top ctm_top_chk i_ctm_top_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_pin_in(timer_pin_in),
  .timer_pin_out(timer_pin_out), .converter_trigger(converter_trigger), .timer_irq(timer_irq));
`default_nettype wire
